/* File: core/bmr_pkg.sv */
// Constants and types for the boot memory read command handler.
`default_nettype none
package bmr_pkg;
	localparam logic [7:0] REQUEST_START_BYTE = 8'h01;
	localparam logic [7:0] DATA_FRAME_HEADER = 8'h81;
	localparam logic [7:0] FRAME_TERMINATOR = 8'h03;
	localparam logic [7:0] CMD_READ = 8'h15;
	localparam logic [7:0] RES_READ_ERR = 8'h95;
	localparam logic [15:0] REQ_LEN = 16'h0009;
	localparam logic [15:0] ACK_LEN = 16'h0001;
	localparam logic [7:0] STATUS_LEN_LO = 8'h0A;
	localparam logic [10:0] STATUS_PAYLOAD = 11'h009;
	localparam logic [10:0] MAX_PAYLOAD = 11'h400;
	localparam logic [11:0] PAYLOAD_IDX = 12'h004;
	localparam logic [31:0] UNUSED_CODE = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
	localparam logic [7:0] STS_OK = 8'h00;
	localparam logic [7:0] STS_PACKET = 8'hC1;
	localparam logic [7:0] STS_CHECKSUM = 8'hC2;
	localparam logic [7:0] STS_ACCEPT = 8'hC3;
	localparam logic [7:0] STS_PARAM = 8'hC5;
	localparam logic [7:0] STS_ADDRESS = 8'hD0;
	localparam logic [7:0] STS_SECURE = 8'hDA;
	localparam logic [1:0] KIND_USER = 2'h0;
	localparam logic [1:0] KIND_DATA = 2'h1;
	localparam logic [1:0] KIND_CONFIG = 2'h2;
	localparam logic [1:0] KIND_OTHER = 2'h3;
	localparam logic [1:0] AUTH_LEVEL_ZERO = 2'h0;
	localparam logic [1:0] AUTH_LEVEL_ONE = 2'h1;
	localparam int AREA_COUNT = 2;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CRC = 8'h08;
	localparam logic [7:0] REG_BOUND_LO = 8'h0C;
	localparam logic [7:0] REG_BOUND_HI = 8'h10;
	localparam logic [7:0] REG_SEC_LO = 8'h14;
	localparam logic [7:0] REG_SEC_HI = 8'h18;
	localparam logic [7:0] REG_AREA_BASE = 8'h20;
	localparam logic [7:0] AREA_STRIDE = 8'h10;
	localparam logic [7:0] AREA_OFF_START = 8'h00;
	localparam logic [7:0] AREA_OFF_END = 8'h04;
	localparam logic [7:0] AREA_OFF_ATTR = 8'h08;
	localparam int CTRL_READ_OK = 0;
	localparam int CTRL_ENC_PEND = 1;
	localparam int CTRL_AUTH_LSB = 2;
	localparam int CTRL_OK_AT_END = 4;
	localparam int STATUS_BUSY = 8;
	localparam int ATTR_RAU_LSB = 8;
	localparam logic [31:0] CTRL_RESET = 32'h00000000;
	localparam logic [31:0] REG_RESET = 32'h00000000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		ST_IDLE, ST_RX_CMD, ST_CHECK, ST_TX, ST_ACK_WAIT, ST_ACK_RX,
		ST_ACK_CHECK
	} bmr_state_t;
endpackage
`default_nettype wire

/* File: core/bmr_read_cmd.sv */
// Memory read command handler: request parser, checks, replies, registers.
`default_nettype none
// Notes on behaviour
// - Request is 01h, 0009h, 15h, addresses, sum, 03h.
// - Data reply: 81h, N+1, 15h, N bytes, sum, 03h.
// - Success status: 0Ah, 15h, 00h, all-ones fields.
// - Error status: 81h, 0Ah, 95h, code, fields.
// - Idle waits for the start byte only.
// - Missing terminator gives packet error.
// - Checksum mismatch gives checksum error.
// - Wrong length bytes give packet error.
// - Any error aborts without touching memory.
// - Lifecycle state forbidding reads gives acceptance error.
// - Pending encrypted write gives acceptance error.
// - Start above end or outside areas: parameter.
// - Different area kinds give parameter error.
// - Zero or misaligned read unit: parameter.
// - Range outside boundary gives invalid address.
// - Level zero, or level one secure overlap unless the start area is of kind other: secure.
// - Report only the highest priority error.
// - Stream range in replies of 1024 bytes max.
// - Bad acknowledgement gives packet or checksum error.
// - Good acknowledgement sends the next block.
// - CRC-32, all-ones start, MSB first, 04C11DB7h.
module bmr_read_cmd (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	output logic tx_valid,
	output logic [7:0] tx_byte,
	input wire logic tx_ready,
	output logic mem_req,
	output logic [31:0] mem_addr,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_rvalid,
	output logic busy,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	bmr_pkg::bmr_state_t st, next_st;
	logic [16:0] rx_cnt;
	logic [15:0] rx_len;
	logic [7:0] rx_sum, rx_code, rx_last;
	logic [31:0] start_address_field, ead;
	logic rx_end;
	logic [31:0] ctrl, bound_lo, bound_hi, sec_lo, sec_hi, crc;
	logic [31:0] area_start [bmr_pkg::AREA_COUNT];
	logic [31:0] area_end [bmr_pkg::AREA_COUNT];
	logic [31:0] area_attr [bmr_pkg::AREA_COUNT];
	logic [bmr_pkg::AREA_COUNT-1:0] hit_s, hit_e;
	logic s_sel, e_sel;
	logic [1:0] s_kind, e_kind, auth;
	logic [7:0] read_access_unit, rau_mask, ead_next_lo;
	logic [7:0] chk_sts, ack_sts, err_code, last_sts;
	logic start_err, start_data, start_ok;
	logic tx_kind_data, tx_load, tx_last, in_payload, byte_ok;
	logic [11:0] tx_idx, sum_idx;
	logic [10:0] tx_n, chunk;
	logic [7:0] tx_sts, tx_sum, tx_res, next_tx_val;
	logic [15:0] tx_len;
	logic fetch_pend, have_byte;
	logic [7:0] fetch_byte;
	logic [32:0] rem_cnt, next_rem;
	logic [7:0] aw_addr;
	logic [31:0] w_data, rd_word;
	logic [3:0] w_strb;
	logic wr_do, wr_hit, rd_hit;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	function automatic logic [31:0] crc_step(input logic [31:0] c,
		input logic [7:0] b);
		logic [31:0] r;
		r = c ^ {b, 24'h000000};
		for (int i = 0; i < 8; i++) begin
			r = r[31] ? ((r << 1) ^ bmr_pkg::CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) r[8*b +: 8] = n[8*b +: 8];
		end
		return r;
	endfunction

	function automatic logic [7:0] area_reg(input int i, input logic [7:0] f);
		return bmr_pkg::REG_AREA_BASE + 8'(i) * bmr_pkg::AREA_STRIDE + f;
	endfunction

	// Receive side: request and acknowledgement frames share one parser.
	assign rx_end = rx_valid && (st == bmr_pkg::ST_RX_CMD ||
		st == bmr_pkg::ST_ACK_RX) && rx_cnt == {1'b0, rx_len} + 17'h00003;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rx_cnt <= '0;
			rx_len <= '0;
			rx_sum <= '0;
			rx_code <= '0;
			rx_last <= '0;
			start_address_field <= '0;
			ead <= '0;
		end else if (rx_valid && (st == bmr_pkg::ST_IDLE ||
			st == bmr_pkg::ST_ACK_WAIT)) begin
			rx_cnt <= '0;
			rx_len <= '0;
			rx_sum <= '0;
		end else if (rx_valid && (st == bmr_pkg::ST_RX_CMD ||
			st == bmr_pkg::ST_ACK_RX)) begin
			rx_cnt <= rx_cnt + 17'h00001;
			if (rx_end) rx_last <= rx_byte;
			else rx_sum <= rx_sum + rx_byte;
			if (rx_cnt == 17'h00000) rx_len[15:8] <= rx_byte;
			if (rx_cnt == 17'h00001) rx_len[7:0] <= rx_byte;
			if (rx_cnt == 17'h00002) rx_code <= rx_byte;
			// Addresses arrive most significant byte first.
			if (st == bmr_pkg::ST_RX_CMD && rx_cnt >= 17'h00003 &&
				rx_cnt <= 17'h00006) start_address_field <= {start_address_field[23:0], rx_byte};
			if (st == bmr_pkg::ST_RX_CMD && rx_cnt >= 17'h00007 &&
				rx_cnt <= 17'h0000A) ead <= {ead[23:0], rx_byte};
		end
	end

	genvar gi;
	for (gi = 0; gi < bmr_pkg::AREA_COUNT; gi++) begin : g_area
		assign hit_s[gi] = start_address_field >= area_start[gi] && start_address_field <= area_end[gi];
		assign hit_e[gi] = ead >= area_start[gi] && ead <= area_end[gi];
	end

	always_comb begin
		s_sel = 1'b0;
		e_sel = 1'b0;
		for (int i = bmr_pkg::AREA_COUNT - 1; i >= 0; i--) begin
			if (hit_s[i]) s_sel = 1'(i);
			if (hit_e[i]) e_sel = 1'(i);
		end
	end

	assign s_kind = area_attr[s_sel][1:0];
	assign e_kind = area_attr[e_sel][1:0];
	assign read_access_unit = area_attr[s_sel][bmr_pkg::ATTR_RAU_LSB +: 8];
	assign rau_mask = read_access_unit - 8'h01;
	assign ead_next_lo = ead[7:0] + 8'h01;
	assign auth = ctrl[bmr_pkg::CTRL_AUTH_LSB +: 2];

	// The read unit is taken as a power of two so alignment is a mask test.
	always_comb begin
		chk_sts = bmr_pkg::STS_OK;
		if (rx_last != bmr_pkg::FRAME_TERMINATOR) begin
			chk_sts = bmr_pkg::STS_PACKET;
		end else if (rx_sum != 8'h00) begin
			chk_sts = bmr_pkg::STS_CHECKSUM;
		end else if (rx_len == 16'h0000 || rx_len != bmr_pkg::REQ_LEN ||
			rx_code != bmr_pkg::CMD_READ) begin
			chk_sts = bmr_pkg::STS_PACKET;
		end else if (!ctrl[bmr_pkg::CTRL_READ_OK] ||
			ctrl[bmr_pkg::CTRL_ENC_PEND]) begin
			chk_sts = bmr_pkg::STS_ACCEPT;
		end else if (start_address_field > ead || hit_s == '0 || hit_e == '0) begin
			chk_sts = bmr_pkg::STS_PARAM;
		end else if (s_kind != e_kind) begin
			chk_sts = bmr_pkg::STS_PARAM;
		end else if (read_access_unit == 8'h00 || (start_address_field[7:0] & rau_mask) != 8'h00 ||
			(ead_next_lo & rau_mask) != 8'h00) begin
			chk_sts = bmr_pkg::STS_PARAM;
		end else if (start_address_field < bound_lo || ead > bound_hi) begin
			chk_sts = bmr_pkg::STS_ADDRESS;
		end else if (auth == bmr_pkg::AUTH_LEVEL_ZERO ||
			(auth == bmr_pkg::AUTH_LEVEL_ONE &&
			s_kind != bmr_pkg::KIND_OTHER &&
			start_address_field <= sec_hi && ead >= sec_lo)) begin
			chk_sts = bmr_pkg::STS_SECURE;
		end
	end

	always_comb begin
		ack_sts = bmr_pkg::STS_OK;
		if (rx_last != bmr_pkg::FRAME_TERMINATOR) begin
			ack_sts = bmr_pkg::STS_PACKET;
		end else if (rx_sum != 8'h00) begin
			ack_sts = bmr_pkg::STS_CHECKSUM;
		end else if (rx_len == 16'h0000 || rx_code != bmr_pkg::CMD_READ ||
			rx_len != bmr_pkg::ACK_LEN) begin
			ack_sts = bmr_pkg::STS_PACKET;
		end
	end

	assign err_code = (st == bmr_pkg::ST_CHECK) ? chk_sts : ack_sts;
	assign start_err = (st == bmr_pkg::ST_CHECK ||
		st == bmr_pkg::ST_ACK_CHECK) && err_code != bmr_pkg::STS_OK;
	assign start_data = (st == bmr_pkg::ST_CHECK ||
		st == bmr_pkg::ST_ACK_CHECK) && err_code == bmr_pkg::STS_OK;
	assign start_ok = tx_load && tx_last && tx_kind_data &&
		rem_cnt == 33'h000000000 && ctrl[bmr_pkg::CTRL_OK_AT_END];

	always_comb begin
		next_st = st;
		unique case (st)
			bmr_pkg::ST_IDLE:
				if (rx_valid && rx_byte == bmr_pkg::REQUEST_START_BYTE)
					next_st = bmr_pkg::ST_RX_CMD;
			bmr_pkg::ST_RX_CMD:
				if (rx_end) next_st = bmr_pkg::ST_CHECK;
			bmr_pkg::ST_CHECK, bmr_pkg::ST_ACK_CHECK:
				next_st = bmr_pkg::ST_TX;
			bmr_pkg::ST_TX: begin
				if (tx_load && tx_last) begin
					if (!tx_kind_data) next_st = bmr_pkg::ST_IDLE;
					else if (start_ok) next_st = bmr_pkg::ST_TX;
					else if (rem_cnt == 33'h000000000)
						next_st = bmr_pkg::ST_IDLE;
					else next_st = bmr_pkg::ST_ACK_WAIT;
				end
			end
			bmr_pkg::ST_ACK_WAIT:
				if (rx_valid && rx_byte == bmr_pkg::DATA_FRAME_HEADER)
					next_st = bmr_pkg::ST_ACK_RX;
			bmr_pkg::ST_ACK_RX:
				if (rx_end) next_st = bmr_pkg::ST_ACK_CHECK;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st <= bmr_pkg::ST_IDLE;
			busy <= 1'b0;
			last_sts <= bmr_pkg::STS_OK;
		end else begin
			st <= next_st;
			busy <= next_st != bmr_pkg::ST_IDLE;
			if (start_err) last_sts <= err_code;
		end
	end

	// Transmit side: status replies are frames with a nine-byte payload.
	assign next_rem = (st == bmr_pkg::ST_CHECK) ?
		{1'b0, ead} - {1'b0, start_address_field} + 33'h000000001 : rem_cnt;
	assign chunk = (next_rem > {22'h000000, bmr_pkg::MAX_PAYLOAD}) ?
		bmr_pkg::MAX_PAYLOAD : next_rem[10:0];
	assign sum_idx = {1'b0, tx_n} + bmr_pkg::PAYLOAD_IDX;
	assign tx_last = tx_idx == sum_idx + 12'h001;
	assign in_payload = tx_idx >= bmr_pkg::PAYLOAD_IDX && tx_idx < sum_idx;
	assign byte_ok = !(tx_kind_data && in_payload) || have_byte;
	assign tx_load = st == bmr_pkg::ST_TX && (!tx_valid || tx_ready) &&
		byte_ok;
	assign tx_len = {5'h00, tx_n} + 16'h0001;
	assign tx_res = (tx_kind_data || tx_sts == bmr_pkg::STS_OK) ?
		bmr_pkg::CMD_READ : bmr_pkg::RES_READ_ERR;

	always_comb begin
		next_tx_val = bmr_pkg::FRAME_TERMINATOR;
		if (tx_idx == 12'h000) next_tx_val = bmr_pkg::DATA_FRAME_HEADER;
		else if (tx_idx == 12'h001) next_tx_val = tx_len[15:8];
		else if (tx_idx == 12'h002) next_tx_val = tx_len[7:0];
		else if (tx_idx == 12'h003) next_tx_val = tx_res;
		else if (in_payload && tx_kind_data) next_tx_val = fetch_byte;
		else if (tx_idx == bmr_pkg::PAYLOAD_IDX) next_tx_val = tx_sts;
		else if (in_payload) next_tx_val = bmr_pkg::UNUSED_CODE[7:0];
		else if (tx_idx == sum_idx) next_tx_val = 8'h00 - tx_sum;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tx_valid <= 1'b0;
			tx_byte <= 8'h00;
			tx_idx <= '0;
			tx_n <= '0;
			tx_sts <= bmr_pkg::STS_OK;
			tx_sum <= 8'h00;
			tx_kind_data <= 1'b0;
		end else begin
			if (tx_load) begin
				tx_valid <= 1'b1;
				tx_byte <= next_tx_val;
				tx_idx <= tx_idx + 12'h001;
				if (tx_idx == 12'h000) tx_sum <= 8'h00;
				else tx_sum <= tx_sum + next_tx_val;
			end else if (tx_ready) begin
				tx_valid <= 1'b0;
			end
			if (start_err || start_ok) begin
				tx_kind_data <= 1'b0;
				tx_idx <= '0;
				tx_n <= bmr_pkg::STATUS_PAYLOAD;
				tx_sts <= start_ok ? bmr_pkg::STS_OK : err_code;
			end else if (start_data) begin
				tx_kind_data <= 1'b1;
				tx_idx <= '0;
				tx_n <= chunk;
				tx_sts <= bmr_pkg::STS_OK;
			end
		end
	end

	// Bytes are fetched one at a time; a read unit is covered by its bytes.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			mem_req <= 1'b0;
			mem_addr <= '0;
			fetch_pend <= 1'b0;
			have_byte <= 1'b0;
			fetch_byte <= 8'h00;
			rem_cnt <= '0;
		end else begin
			mem_req <= 1'b0;
			if (st == bmr_pkg::ST_CHECK) begin
				mem_addr <= start_address_field;
				rem_cnt <= next_rem;
			end
			if (st == bmr_pkg::ST_TX && tx_kind_data && in_payload &&
				!have_byte && !fetch_pend) begin
				mem_req <= 1'b1;
				fetch_pend <= 1'b1;
			end
			if (mem_rvalid && fetch_pend) begin
				have_byte <= 1'b1;
				fetch_byte <= mem_rdata;
				fetch_pend <= 1'b0;
			end
			if (tx_load && tx_kind_data && in_payload) begin
				have_byte <= 1'b0;
				mem_addr <= mem_addr + 32'h00000001;
				rem_cnt <= rem_cnt - 33'h000000001;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset || st == bmr_pkg::ST_CHECK) crc <= bmr_pkg::CRC_INIT;
		else if (tx_load && tx_kind_data && in_payload)
			crc <= crc_step(crc, fetch_byte);
	end

	// Register bus: write address and data are taken in either order.
	assign wr_do = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	always_comb begin
		rd_hit = 1'b1;
		rd_word = 32'h00000000;
		wr_hit = aw_addr == bmr_pkg::REG_CTRL ||
			aw_addr == bmr_pkg::REG_STATUS || aw_addr == bmr_pkg::REG_CRC ||
			aw_addr == bmr_pkg::REG_BOUND_LO ||
			aw_addr == bmr_pkg::REG_BOUND_HI ||
			aw_addr == bmr_pkg::REG_SEC_LO || aw_addr == bmr_pkg::REG_SEC_HI;
		case (s_axi_araddr)
			bmr_pkg::REG_CTRL: rd_word = ctrl;
			bmr_pkg::REG_STATUS: rd_word = {23'h000000, busy, last_sts};
			bmr_pkg::REG_CRC: rd_word = crc;
			bmr_pkg::REG_BOUND_LO: rd_word = bound_lo;
			bmr_pkg::REG_BOUND_HI: rd_word = bound_hi;
			bmr_pkg::REG_SEC_LO: rd_word = sec_lo;
			bmr_pkg::REG_SEC_HI: rd_word = sec_hi;
			default: rd_hit = 1'b0;
		endcase
		for (int i = 0; i < bmr_pkg::AREA_COUNT; i++) begin
			if (aw_addr == area_reg(i, bmr_pkg::AREA_OFF_START) ||
				aw_addr == area_reg(i, bmr_pkg::AREA_OFF_END) ||
				aw_addr == area_reg(i, bmr_pkg::AREA_OFF_ATTR)) wr_hit = 1'b1;
			if (s_axi_araddr == area_reg(i, bmr_pkg::AREA_OFF_START)) begin
				rd_hit = 1'b1;
				rd_word = area_start[i];
			end
			if (s_axi_araddr == area_reg(i, bmr_pkg::AREA_OFF_END)) begin
				rd_hit = 1'b1;
				rd_word = area_end[i];
			end
			if (s_axi_araddr == area_reg(i, bmr_pkg::AREA_OFF_ATTR)) begin
				rd_hit = 1'b1;
				rd_word = area_attr[i];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrl <= bmr_pkg::CTRL_RESET;
			bound_lo <= bmr_pkg::REG_RESET;
			bound_hi <= bmr_pkg::REG_RESET;
			sec_lo <= bmr_pkg::REG_RESET;
			sec_hi <= bmr_pkg::REG_RESET;
			for (int i = 0; i < bmr_pkg::AREA_COUNT; i++) begin
				area_start[i] <= bmr_pkg::REG_RESET;
				area_end[i] <= bmr_pkg::REG_RESET;
				area_attr[i] <= bmr_pkg::REG_RESET;
			end
		end else if (wr_do) begin
			if (aw_addr == bmr_pkg::REG_CTRL) ctrl <= merge(ctrl, w_data, w_strb);
			if (aw_addr == bmr_pkg::REG_BOUND_LO)
				bound_lo <= merge(bound_lo, w_data, w_strb);
			if (aw_addr == bmr_pkg::REG_BOUND_HI)
				bound_hi <= merge(bound_hi, w_data, w_strb);
			if (aw_addr == bmr_pkg::REG_SEC_LO)
				sec_lo <= merge(sec_lo, w_data, w_strb);
			if (aw_addr == bmr_pkg::REG_SEC_HI)
				sec_hi <= merge(sec_hi, w_data, w_strb);
			for (int i = 0; i < bmr_pkg::AREA_COUNT; i++) begin
				if (aw_addr == area_reg(i, bmr_pkg::AREA_OFF_START))
					area_start[i] <= merge(area_start[i], w_data, w_strb);
				if (aw_addr == area_reg(i, bmr_pkg::AREA_OFF_END))
					area_end[i] <= merge(area_end[i], w_data, w_strb);
				if (aw_addr == area_reg(i, bmr_pkg::AREA_OFF_ATTR))
					area_attr[i] <= merge(area_attr[i], w_data, w_strb);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= bmr_pkg::RESP_OKAY;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_do) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? bmr_pkg::RESP_OKAY : bmr_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= bmr_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? bmr_pkg::RESP_OKAY : bmr_pkg::RESP_SLVERR;
			s_axi_rvalid <= 1'b1;
			s_axi_arready <= 1'b0;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	sequence s_cmd_end;
		st == bmr_pkg::ST_RX_CMD && rx_end;
	endsequence
	sequence s_ack_good;
		st == bmr_pkg::ST_ACK_CHECK && ack_sts == bmr_pkg::STS_OK;
	endsequence

	a_idle_start_only: assert property (st == bmr_pkg::ST_IDLE && rx_valid &&
		rx_byte != bmr_pkg::REQUEST_START_BYTE |=> st == bmr_pkg::ST_IDLE)
		else $error("Idle left on a non-start byte.");
	a_term_missing: assert property (s_cmd_end ##1
		(rx_last != bmr_pkg::FRAME_TERMINATOR) |=>
		!tx_kind_data && tx_sts == bmr_pkg::STS_PACKET)
		else $error("Missing terminator not reported as packet error.");
	a_sum_mismatch: assert property (s_cmd_end ##1
		(rx_last == bmr_pkg::FRAME_TERMINATOR && rx_sum != 8'h00) |=>
		tx_sts == bmr_pkg::STS_CHECKSUM)
		else $error("Checksum mismatch not reported.");
	a_accept_block: assert property (st == bmr_pkg::ST_CHECK &&
		chk_sts != bmr_pkg::STS_CHECKSUM && rx_len == bmr_pkg::REQ_LEN &&
		rx_last == bmr_pkg::FRAME_TERMINATOR && rx_sum == 8'h00 &&
		rx_code == bmr_pkg::CMD_READ && !ctrl[bmr_pkg::CTRL_READ_OK] |=>
		tx_sts == bmr_pkg::STS_ACCEPT)
		else $error("Forbidden lifecycle did not give acceptance error.");
	a_level_zero_secure: assert property (st == bmr_pkg::ST_CHECK &&
		auth == bmr_pkg::AUTH_LEVEL_ZERO |=> !tx_kind_data)
		else $error("Data sent at authentication level zero.");
	a_no_mem_on_err: assert property (st == bmr_pkg::ST_TX &&
		!tx_kind_data |-> !mem_req)
		else $error("Memory read during a status reply.");
	a_reply_header: assert property (tx_load && tx_idx == 12'h000 |=>
		tx_valid && tx_byte == bmr_pkg::DATA_FRAME_HEADER)
		else $error("Reply does not open with the header byte.");
	a_err_code: assert property (tx_load && tx_idx == 12'h003 &&
		!tx_kind_data && tx_sts != bmr_pkg::STS_OK |=>
		tx_byte == bmr_pkg::RES_READ_ERR)
		else $error("Error reply has the wrong response code.");
	a_status_len: assert property (tx_load && tx_idx == 12'h002 &&
		!tx_kind_data |=> tx_byte == bmr_pkg::STATUS_LEN_LO)
		else $error("Status reply has the wrong length.");
	a_chunk_bound: assert property (st == bmr_pkg::ST_TX &&
		tx_kind_data |-> tx_n != 11'h000 && tx_n <= bmr_pkg::MAX_PAYLOAD)
		else $error("Data reply payload out of range.");
	a_ack_discard: assert property (st == bmr_pkg::ST_ACK_WAIT &&
		rx_valid && rx_byte != bmr_pkg::DATA_FRAME_HEADER |=>
		st == bmr_pkg::ST_ACK_WAIT)
		else $error("Junk byte ended the acknowledgement wait.");
	a_ack_resume: assert property (s_ack_good |=>
		st == bmr_pkg::ST_TX && tx_kind_data && tx_idx == 12'h000)
		else $error("Good acknowledgement did not start the next block.");
	a_frame_end: assert property (tx_load && tx_last |=>
		tx_byte == bmr_pkg::FRAME_TERMINATOR)
		else $error("Reply does not end with the terminator.");
endmodule // bmr_read_cmd
`default_nettype wire

/* File: dv/bmr_host.sv */
// Host tool model on the serial command link.
`default_nettype none
module bmr_host (
	input wire logic clk_sys,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	input wire logic tx_valid,
	input wire logic [7:0] tx_byte,
	output logic tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got[$];
	initial begin
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		tx_ready = 1'b0;
	end
	// Random stalls prove that a reply byte holds until it is taken.
	always @(posedge clk_sys) begin
		if (tx_valid && tx_ready)
			got.push_back(tx_byte);
		tx_ready <= 1'($urandom % 2);
	end
	task automatic send(input logic [7:0] q[$]);
		foreach (q[i]) begin
			@(posedge clk_sys);
			rx_valid <= 1'b1;
			rx_byte <= q[i];
		end
		@(posedge clk_sys);
		rx_valid <= 1'b0;
		rx_byte <= ~q[q.size() - 1];
	endtask
endmodule // bmr_host
`default_nettype wire

/* File: dv/test_boot_memory_read_command.sv */
// Bench for the memory read command handler.
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin n_errors++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_boot_memory_read_command;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, reset, rx_valid, tx_valid, tx_ready, mem_req, busy;
	logic [7:0] rx_byte, tx_byte, s_axi_awaddr, s_axi_araddr;
	logic [31:0] mem_addr, s_axi_wdata, s_axi_rdata, sa;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, mem_rvalid = 1'b0;
	logic [7:0] mem_rdata = 8'h00;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int n_errors = 0, checks = 0, n_mem = 0, n;
	logic [7:0] exp[$], pl[$];
	bmr_read_cmd u_bmr_read_cmd (.clk_sys, .reset, .rx_valid, .rx_byte,
		.tx_valid, .tx_byte, .tx_ready, .mem_req, .mem_addr, .mem_rdata,
		.mem_rvalid, .busy, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	bmr_host u_bmr_host (.clk_sys, .rx_valid, .rx_byte, .tx_valid, .tx_byte,
		.tx_ready);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Each byte carries a mark of its own address.
	always @(posedge clk_sys) begin
		mem_rvalid <= mem_req;
		mem_rdata <= mem_addr[7:0] ^ 8'hA5;
		n_mem <= n_mem + int'(mem_req);
	end
	task automatic stop_test();
		if (n_errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	function automatic void frame(input logic [7:0] r, input logic [7:0] p[$]);
		logic [15:0] l;
		logic [7:0] s;
		l = 16'(p.size() + 1);
		s = l[15:8] + l[7:0] + r;
		foreach (p[i]) s += p[i];
		exp = {exp, 8'h81, l[15:8], l[7:0], r, p, 8'(-s), 8'h03};
	endfunction
	function automatic void sts(input logic [7:0] r, c);
		frame(r, {c, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF});
	endfunction
	function automatic void dat(input logic [31:0] a, input int k);
		pl = {};
		for (int i = 0; i < k; i++)
			pl.push_back(8'(a + i) ^ 8'hA5);
		frame(8'h15, pl);
	endfunction
	function automatic logic [31:0] crc(input logic [7:0] p[$]);
		logic [31:0] c;
		c = 32'hFFFFFFFF;
		foreach (p[i]) begin
			c ^= {p[i], 24'h000000};
			repeat (8)
				c = c[31] ? (c << 1) ^ 32'h04C11DB7 : c << 1;
		end
		return c;
	endfunction
	// A junk byte ahead of the header must be dropped by the device.
	task automatic ack(input logic [7:0] r);
		u_bmr_host.send({8'h55, 8'h81, 8'h00, 8'h01, r, 8'hFF - r, 8'h03});
	endtask
	task automatic req(input logic [31:0] a, e, input logic [7:0] d, t);
		logic [7:0] q[$];
		logic [7:0] s;
		q = {8'h00, 8'h09, 8'h15};
		for (int i = 3; i >= 0; i--)
			q = {q, a[8*i +: 8]};
		for (int i = 3; i >= 0; i--)
			q = {q, e[8*i +: 8]};
		s = d;
		foreach (q[i]) s -= q[i];
		u_bmr_host.send({8'h55, 8'h01, q, s, t});
	endtask
	task automatic cmp();
		int k;
		k = 0;
		while (u_bmr_host.got.size() < exp.size() && k < 20000) begin
			@(posedge clk_sys);
			k++;
		end
		repeat (30) @(posedge clk_sys);
		`CHK("length", exp.size(), u_bmr_host.got.size())
		foreach (exp[i]) `CHK("byte", exp[i], u_bmr_host.got[i])
		exp = {};
		u_bmr_host.got = {};
	endtask
	task automatic err(input logic [31:0] a, e, input logic [7:0] d, t, c);
		req(a, e, d, t);
		sts(8'h95, c);
		cmp();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		logic [1:0] r;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		tb = 1'b0;
		while (!tb) begin
			@(negedge clk_sys);
			{ta, tw, tb, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid,
				s_axi_bresp};
			@(posedge clk_sys);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		`CHK("bresp", a == 8'hF0 ? 2'h2 : 2'h0, r)
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic t, ta;
		logic [33:0] g;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		t = 1'b0;
		while (!t) begin
			@(negedge clk_sys);
			{t, ta, g} = {s_axi_rvalid, s_axi_arready, s_axi_rresp, s_axi_rdata};
			@(posedge clk_sys);
			if (ta)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		`CHK("register", {a == 8'hF0 ? 2'h2 : 2'h0, e}, g)
	endtask
	initial begin
		void'($urandom(32'h96faec7c));
		reset = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
		{s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 49'h0;
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		rd(8'h00, 32'h0);
		rd(8'hF0, 32'h0);
		wr(8'hF0, 32'h0);
		err(32'h10, 32'h13, 8'h00, 8'h03, 8'hC3);
		wr(8'h24, 32'h0000FFFF);
		wr(8'h28, 32'h00000100);
		wr(8'h10, 32'h0000FFFF);
		wr(8'h00, 32'h0000000B);
		err(32'h10, 32'h13, 8'h00, 8'h03, 8'hC3);
		wr(8'h00, 32'h00000009);
		err(32'h10, 32'h13, 8'h01, 8'h04, 8'hC1);
		err(32'h10, 32'h13, 8'h01, 8'h03, 8'hC2);
		err(32'h13, 32'h10, 8'h00, 8'h03, 8'hC5);
		err(32'h10, 32'h10000, 8'h00, 8'h03, 8'hC5);
		wr(8'h34, 32'h0001FFFF);
		wr(8'h38, 32'h00000001);
		err(32'hFFF0, 32'h10003, 8'h00, 8'h03, 8'hC5);
		wr(8'h28, 32'h00000200);
		err(32'h11, 32'h13, 8'h00, 8'h03, 8'hC5);
		wr(8'h28, 32'h00000000);
		err(32'h10, 32'h13, 8'h00, 8'h03, 8'hC5);
		wr(8'h28, 32'h00000100);
		wr(8'h10, 32'h000000FF);
		err(32'hF0, 32'h103, 8'h00, 8'h03, 8'hD0);
		wr(8'h10, 32'h0000FFFF);
		wr(8'h00, 32'h00000005);
		err(32'h0, 32'h3, 8'h00, 8'h03, 8'hDA);
		wr(8'h00, 32'h00000001);
		err(32'h10, 32'h13, 8'h00, 8'h03, 8'hDA);
		rd(8'h04, 32'h000000DA);
		`CHK("mem_req", 0, n_mem)
		wr(8'h00, 32'h00000009);
		sa = 32'h100 + $urandom % 256;
		n = 1 + $urandom % 16;
		req(sa, sa + n - 1, 8'h00, 8'h03);
		dat(sa, n);
		cmp();
		rd(8'h08, crc(pl));
		wr(8'h00, 32'h00000019);
		req(32'h1000, 32'h1400, 8'h00, 8'h03);
		dat(32'h1000, 1024);
		cmp();
		`CHK("busy", 1'b1, busy)
		ack(8'h15);
		dat(32'h1400, 1);
		sts(8'h15, 8'h00);
		cmp();
		req(32'h1000, 32'h1400, 8'h00, 8'h03);
		dat(32'h1000, 1024);
		cmp();
		ack(8'h16);
		sts(8'h95, 8'hC1);
		cmp();
		`CHK("busy", 1'b0, busy)
		stop_test();
	end
	initial begin
		repeat (60000) @(posedge clk_sys);
		n_errors++;
		stop_test();
	end
endmodule // test_boot_memory_read_command
`default_nettype wire
